// ===== hw/ppe_port_pin_event_irq.sv
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "ppe_regs.svh"

module ppe_port_pin_event_irq (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone classic slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`PPE_ADR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [`PPE_DAT_W-1:0]    wb_dat_i,
    output logic      [`PPE_DAT_W-1:0]    wb_dat_o,
    output logic                          wb_ack_o,
    // Sample clock ticks, one-cycle pulses in the clk_i domain
    input  wire logic                     low_speed_tick_i,
    input  wire logic                     high_speed_tick_i,
    // Port pins, asynchronous
    input  wire logic [13:0]              port_g_pins_i,
    input  wire logic [12:0]              port_h_pins_i,
    // Interrupt requests
    output logic                          port_g_irq_o,
    output logic                          port_h_irq_o,
    output logic                          irq_o
);

    ppe_pkg::ppe_state_t s;
    ppe_pkg::ppe_state_t next_s;

    // Trigger decode of one line; reserved codes never fire
    function automatic logic trig_hit(
        input logic [`PPE_MODE_W-1:0] mode,
        input logic                   cur,
        input logic                   prev
    );
        logic hit;
        case (mode)
            `PPE_MODE_RISE: hit = cur & ~prev;
            `PPE_MODE_FALL: hit = ~cur & prev;
            `PPE_MODE_HIGH: hit = cur;
            `PPE_MODE_LOW:  hit = ~cur;
            `PPE_MODE_BOTH: hit = cur ^ prev;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [`PPE_DAT_W-1:0] lane_merge(
        input logic [`PPE_DAT_W-1:0] old,
        input logic [`PPE_DAT_W-1:0] wdat,
        input logic [3:0]            sel
    );
        logic [`PPE_DAT_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Sample clock register image
    function automatic logic [`PPE_DAT_W-1:0] smp_word(
        input ppe_pkg::ppe_sample_t smp
    );
        logic [`PPE_DAT_W-1:0] w;
        w = `PPE_WORD_ZERO;
        w[`PPE_SRC_BIT] = smp.src;
        w[`PPE_EXP_MSB:`PPE_EXP_LSB] = smp.exp;
        return w;
    endfunction

    // Prescaler, synchroniser, event detect and pending update of one group
    function automatic ppe_pkg::ppe_group_t group_step(
        input ppe_pkg::ppe_group_t     grp,
        input logic [13:0]             pins,
        input logic                    lo_tick,
        input logic                    hi_tick,
        input logic [13:0]             lmask,
        input logic [13:0]             clr
    );
        ppe_pkg::ppe_group_t n;
        logic                  tick;
        logic                  strobe;
        logic [`PPE_DIV_W-1:0] lim;
        logic [13:0]           hit;
        n = grp;
        // Second flop alone reads the first
        n.sync1 = pins;
        n.sync2 = grp.sync1;
        tick = grp.smp.src ? hi_tick : lo_tick;
        lim = `PPE_DIV_FULL >> (`PPE_EXP_MAX - grp.smp.exp);
        strobe = tick && (grp.div_cnt >= lim);
        if (tick) begin
            n.div_cnt = strobe ? '0 : grp.div_cnt + `PPE_DIV_ONE;
        end
        hit = '0;
        if (strobe) begin
            n.prev = grp.sync2;
            for (int i = 0; i < `PPE_MAX_LINES; i++) begin
                hit[i] = trig_hit(grp.mode[i], grp.sync2[i], grp.prev[i]);
            end
        end
        // New event wins over a same-cycle clear
        n.pend = ((grp.pend & ~clr) | hit) & lmask;
        n.irq = |(n.pend & n.en);
        return n;
    endfunction

    logic                  access;
    logic                  wr;
    logic [`PPE_DAT_W-1:0] clr_word;
    logic [`PPE_DAT_W-1:0] tmp;
    logic [13:0]           g_clr;
    logic [13:0]           h_clr;

    // Bus decode; a write commits at the edge where the master sees ack
    assign access = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
    assign clr_word = lane_merge(`PPE_WORD_ZERO, wb_dat_i, wb_sel_i);
    assign g_clr = (wr && wb_adr_i == `PPE_G_PENDING) ?
                   clr_word[13:0] : '0;
    assign h_clr = (wr && wb_adr_i == `PPE_H_PENDING) ?
                   clr_word[13:0] : '0;

    // Next state: register writes, read data, group event logic
    always_comb begin
        next_s = s;
        tmp = `PPE_WORD_ZERO;
        next_s.ack = access;
        if (access) begin
            // Read image; unmapped and reserved words read zero
            next_s.rdat = `PPE_WORD_ZERO;
            case (wb_adr_i)
                `PPE_G_MODE_LO: next_s.rdat = s.g.mode[7:0];
                `PPE_G_MODE_HI: next_s.rdat = {8'h00, s.g.mode[13:8]};
                `PPE_G_ENABLE:  next_s.rdat = {18'h00000, s.g.en};
                `PPE_G_PENDING: next_s.rdat = {18'h00000, s.g.pend};
                `PPE_G_SAMPLE:  next_s.rdat = smp_word(s.g.smp);
                `PPE_H_MODE_LO: next_s.rdat = s.h.mode[7:0];
                `PPE_H_MODE_HI: next_s.rdat = {12'h000, s.h.mode[12:8]};
                `PPE_H_ENABLE:  next_s.rdat = {18'h00000, s.h.en};
                `PPE_H_PENDING: next_s.rdat = {18'h00000, s.h.pend};
                `PPE_H_SAMPLE:  next_s.rdat = smp_word(s.h.smp);
                default:        next_s.rdat = `PPE_WORD_ZERO;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                `PPE_G_MODE_LO: begin
                    next_s.g.mode[7:0] = lane_merge(s.g.mode[7:0],
                                                    wb_dat_i, wb_sel_i);
                end
                `PPE_G_MODE_HI: begin
                    tmp = lane_merge({8'h00, s.g.mode[13:8]},
                                     wb_dat_i, wb_sel_i);
                    next_s.g.mode[13:8] = tmp[23:0];
                end
                `PPE_G_ENABLE: begin
                    tmp = lane_merge({18'h00000, s.g.en}, wb_dat_i, wb_sel_i);
                    next_s.g.en = tmp[13:0] & `PPE_G_LINE_MASK;
                end
                `PPE_G_SAMPLE: begin
                    tmp = lane_merge(smp_word(s.g.smp), wb_dat_i, wb_sel_i);
                    next_s.g.smp.src = tmp[`PPE_SRC_BIT];
                    next_s.g.smp.exp = tmp[`PPE_EXP_MSB:`PPE_EXP_LSB];
                end
                `PPE_H_MODE_LO: begin
                    next_s.h.mode[7:0] = lane_merge(s.h.mode[7:0],
                                                    wb_dat_i, wb_sel_i);
                end
                `PPE_H_MODE_HI: begin
                    tmp = lane_merge({12'h000, s.h.mode[12:8]},
                                     wb_dat_i, wb_sel_i);
                    next_s.h.mode[12:8] = tmp[19:0];
                end
                `PPE_H_ENABLE: begin
                    tmp = lane_merge({18'h00000, s.h.en}, wb_dat_i, wb_sel_i);
                    next_s.h.en = tmp[13:0] & `PPE_H_LINE_MASK;
                end
                `PPE_H_SAMPLE: begin
                    tmp = lane_merge(smp_word(s.h.smp), wb_dat_i, wb_sel_i);
                    next_s.h.smp.src = tmp[`PPE_SRC_BIT];
                    next_s.h.smp.exp = tmp[`PPE_EXP_MSB:`PPE_EXP_LSB];
                end
                default: begin
                    tmp = `PPE_WORD_ZERO;
                end
            endcase
        end
        // Event logic runs after the writes so new settings apply at once
        next_s.g = group_step(next_s.g, port_g_pins_i, low_speed_tick_i,
                              high_speed_tick_i, `PPE_G_LINE_MASK, g_clr);
        next_s.h = group_step(next_s.h, {1'b0, port_h_pins_i},
                              low_speed_tick_i, high_speed_tick_i,
                              `PPE_H_LINE_MASK, h_clr);
        next_s.irq = next_s.g.irq | next_s.h.irq;
    end

    // State register; reset zeroes every field
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign port_g_irq_o = s.g.irq;
    assign port_h_irq_o = s.h.irq;
    assign irq_o = s.irq;

endmodule // ppe_port_pin_event_irq

// ===== hw/ppe_regs.svh
`ifndef PPE_REGS_SVH
`define PPE_REGS_SVH

// Bus geometry
`define PPE_ADR_W        12
`define PPE_DAT_W        32
`define PPE_WORD_ZERO    32'h0000_0000

// Register byte offsets
`define PPE_G_MODE_LO    12'h2c0
`define PPE_G_MODE_HI    12'h2c4
`define PPE_G_MODE_SP0   12'h2c8
`define PPE_G_MODE_SP1   12'h2cc
`define PPE_G_ENABLE     12'h2d0
`define PPE_G_PENDING    12'h2d4
`define PPE_G_SAMPLE     12'h2d8
`define PPE_H_MODE_LO    12'h2e0
`define PPE_H_MODE_HI    12'h2e4
`define PPE_H_MODE_SP0   12'h2e8
`define PPE_H_MODE_SP1   12'h2ec
`define PPE_H_ENABLE     12'h2f0
`define PPE_H_PENDING    12'h2f4
`define PPE_H_SAMPLE     12'h2f8

// Line counts and implemented-bit masks
`define PPE_MAX_LINES    14
`define PPE_G_LINE_MASK  14'h3fff
`define PPE_H_LINE_MASK  14'h1fff

// Trigger mode codes
`define PPE_MODE_W       4
`define PPE_MODE_RISE    4'h0
`define PPE_MODE_FALL    4'h1
`define PPE_MODE_HIGH    4'h2
`define PPE_MODE_LOW     4'h3
`define PPE_MODE_BOTH    4'h4

// Sample clock register fields
`define PPE_SRC_BIT      0
`define PPE_EXP_LSB      4
`define PPE_EXP_MSB      6
`define PPE_EXP_W        3
`define PPE_EXP_MAX      3'h7
`define PPE_DIV_W        7
`define PPE_DIV_FULL     7'h7f
`define PPE_DIV_ONE      7'h01

`endif

// ===== hw/ppe_pkg.sv
`include "ppe_regs.svh"

package ppe_pkg;

    // Sample clock control of one group
    typedef struct packed {
        logic [`PPE_EXP_W-1:0] exp;
        logic                  src;
    } ppe_sample_t;

    // All state of one port group
    typedef struct packed {
        logic [`PPE_MAX_LINES-1:0][`PPE_MODE_W-1:0] mode;
        logic [`PPE_MAX_LINES-1:0]                  en;
        logic [`PPE_MAX_LINES-1:0]                  pend;
        logic [`PPE_MAX_LINES-1:0]                  sync1;
        logic [`PPE_MAX_LINES-1:0]                  sync2;
        logic [`PPE_MAX_LINES-1:0]                  prev;
        logic [`PPE_DIV_W-1:0]                      div_cnt;
        ppe_sample_t                                smp;
        logic                                       irq;
    } ppe_group_t;

    // Whole block state
    typedef struct packed {
        logic                  ack;
        logic [`PPE_DAT_W-1:0] rdat;
        logic                  irq;
        ppe_group_t            g;
        ppe_group_t            h;
    } ppe_state_t;

endpackage

// ===== verif/ppe_irq_sva.sv
`timescale 1ns/1ps
module ppe_irq_sva (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Interrupt requests
    input wire logic        port_g_irq_o,
    input wire logic        port_h_irq_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answer timing
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    // Interrupt outputs follow pending and enable
    a_irq_merge: assert property (
        irq_o == (port_g_irq_o || port_h_irq_o)) else $error("irq merge");
    a_irq_drop_write: assert property (
        $fell(port_g_irq_o)
        |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o))
        else $error("irq fell without write");
    // Reserved bits read back as zero
    a_g_pend_rsvd: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h2d4)
        |-> wb_dat_o[31:14] == 18'h0) else $error("g pending reserved");
    a_h_pend_rsvd: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h2f4)
        |-> wb_dat_o[31:13] == 19'h0) else $error("h pending reserved");
    a_spare_zero: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i[11:3] == 9'h05d)
        |-> wb_dat_o == 32'h0) else $error("spare word not zero");
    a_sample_rsvd: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h2d8)
        |-> wb_dat_o[31:7] == 25'h0 && wb_dat_o[3:1] == 3'h0)
        else $error("sample reserved bits");
    // Main scenarios seen
    c_irq: cover property ($rose(irq_o));
    c_h_irq: cover property ($rose(port_h_irq_o));
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule // ppe_irq_sva

bind ppe_port_pin_event_irq ppe_irq_sva u_sva (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .port_g_irq_o,
    .port_h_irq_o, .irq_o);

// ===== verif/ppe_pin_model.sv
`timescale 1ns/1ps
module ppe_pin_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Requested pin levels and oscillator gates
    input  wire logic [26:0] level_i,
    input  wire logic        lo_run_i,
    input  wire logic        hi_run_i,
    // Pins and oscillator ticks
    output logic      [13:0] g_pins_o,
    output logic      [12:0] h_pins_o,
    output logic             lo_tick_o,
    output logic             hi_tick_o
);
    logic [1:0] cnt;
    // High-speed tick every 2 cycles, low-speed every 4; pins follow level
    always_ff @(posedge clk_i) begin
        cnt <= rst_i ? 2'h0 : cnt + 2'h1;
        lo_tick_o <= lo_run_i && cnt == 2'h3;
        hi_tick_o <= hi_run_i && cnt[0];
        {h_pins_o, g_pins_o} <= level_i;
    end
endmodule // ppe_pin_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, lo_run, hi_run, lo_t, hi_t;
    logic        g_irq, h_irq, irq;
    logic [11:0] adr;
    logic [31:0] wd, rq, q;
    logic [26:0] lvl;
    logic [13:0] g_pins;
    logic [12:0] h_pins;
    int          errors, tests_run, now, t0;
    // Rows: mode code, level before, level after, pending expected
    logic [6:0]  tbl [10] = '{7'b0000011, 7'b0000100, 7'b0001101,
        7'b0001010, 7'b0010011, 7'b0011101, 7'b0101010, 7'b1111100,
        7'b0100101, 7'b0100011};
    // Clock and cycle count
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) now <= now + 1;
    ppe_pin_model u_pins (.clk_i, .rst_i, .level_i(lvl), .lo_run_i(lo_run),
        .hi_run_i(hi_run), .g_pins_o(g_pins), .h_pins_o(h_pins),
        .lo_tick_o(lo_t), .hi_tick_o(hi_t));
    ppe_port_pin_event_irq u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wd), .wb_dat_o(rq), .wb_ack_o(ack),
        .low_speed_tick_i(lo_t), .high_speed_tick_i(hi_t),
        .port_g_pins_i(g_pins), .port_h_pins_i(h_pins),
        .port_g_irq_o(g_irq), .port_h_irq_o(h_irq), .irq_o(irq));
    task automatic check(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rq;
        {cyc, stb} <= 2'b00;
        check("ack wait", n, 32'd2);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), q, e);
    endtask
    task automatic pause();
        repeat (30) @(posedge clk_i);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #1ms;
        check("watchdog", 32'h0, 32'h1);
        end_of_test();
    end
    initial begin
        {cyc, stb, we, adr, wd, lvl, hi_run} = '0;
        lo_run = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Whole map after reset, unmapped words included
        for (int a = 'h2c0; a < 'h300; a += 4) rd(a[11:0], 32'h0);
        // Implemented bits only
        wr(12'h2e4, 32'hffff_ffff);
        rd(12'h2e4, 32'h000f_ffff);
        wr(12'h2f0, 32'hffff_ffff);
        rd(12'h2f0, 32'h0000_1fff);
        wr(12'h2d8, 32'hffff_ffff);
        rd(12'h2d8, 32'h0000_0071);
        wr(12'h2e8, 32'hffff_ffff);
        rd(12'h2e8, 32'h0);
        wr(12'h2d8, 32'h0);
        wr(12'h2d0, 32'h1);
        // Each defined trigger code, plus reserved codes 5 and 15, on port G line 0
        for (int i = 0; i < 10; i++) begin
            wr(12'h2c0, {28'h0, tbl[i][6:3]});
            lvl[0] <= tbl[i][2];
            pause();
            wr(12'h2d4, 32'h1);
            lvl[0] <= tbl[i][1];
            pause();
            rd(12'h2d4, {31'h0, tbl[i][0]});
            check("irq", {31'h0, irq}, {31'h0, tbl[i][0]});
            check("g irq", {31'h0, g_irq}, {31'h0, tbl[i][0]});
        end
        // Zero write keeps pending; disabling drops the request
        wr(12'h2d4, 32'h0);
        rd(12'h2d4, 32'h1);
        wr(12'h2d0, 32'h0);
        @(posedge clk_i);
        check("irq off", {31'h0, irq}, 32'h0);
        check("g irq off", {31'h0, g_irq}, 32'h0);
        wr(12'h2d4, 32'h1);
        // Only the selected oscillator strobes
        wr(12'h2c0, 32'h1);
        {lo_run, hi_run} <= 2'b01;
        lvl[0] <= 1'b0;
        pause();
        rd(12'h2d4, 32'h0);
        wr(12'h2d8, 32'h1);
        pause();
        rd(12'h2d4, 32'h1);
        // Low-level strobes repeat every 128 high-speed ticks
        wr(12'h2c0, 32'h3);
        wr(12'h2d8, 32'h71);
        for (int k = 0; k < 2; k++) begin
            wr(12'h2d4, 32'h1);
            t0 = now;
            q = '0;
            for (int n = 0; n < 200 && q[0] !== 1'b1; n++)
                bus(1'b0, 12'h2d4, 32'h0);
        end
        check("gap", {31'h0, now - t0 > 240 && now - t0 < 260}, 1);
        // Port H line 12, falling code in the upper mode word
        lo_run <= 1'b1;
        wr(12'h2e4, 32'h0001_0000);
        wr(12'h2f0, 32'h0000_1000);
        lvl[26] <= 1'b1;
        pause();
        wr(12'h2f4, 32'hffff_ffff);
        lvl[26] <= 1'b0;
        pause();
        rd(12'h2f4, 32'h0000_1000);
        check("h irq", {31'h0, h_irq}, 32'h1);
        end_of_test();
    end
endmodule // testbench
